// file: rtl/link_frame_pkg.sv
// package: word layout, addresses and timing counts for the link framer
// assumes a 40 MHz core clock
package link_frame_pkg;
   localparam int          CLK_MHZ        = 40;
   localparam int          NARROW_DATA    = 21;
   localparam int          WIDE_DATA      = 29;
   localparam int          WORD_W         = 32;
   localparam int          PAR_IN_W       = 29;
   localparam int          NARROW_PAR_POS = 23;
   localparam int          WIDE_PAR_POS   = 31;
   localparam logic [7:0]  SER_ADDR_RST   = 8'h80;
   localparam logic [7:0]  DES_ADDR_RST   = 8'h90;
   localparam int          POWERUP_US     = 500;
   localparam int          POWERUP_CYC    = POWERUP_US * CLK_MHZ;
   localparam int          BLOCK_US       = 350;
   localparam int          BLOCK_CYC      = BLOCK_US * CLK_MHZ;
   localparam logic [15:0] SCRAM_SEED     = 16'hffff;
   localparam logic [3:0]  REG_SER_ADDR   = 4'h0;
   localparam logic [3:0]  REG_DES_ADDR   = 4'h1;
   localparam logic [3:0]  REG_CTRL       = 4'h2;
   localparam logic [3:0]  REG_ERR_THR    = 4'h3;
   localparam logic [3:0]  REG_STATUS     = 4'h4;
   localparam logic [3:0]  REG_ERR_CNT    = 4'h5;
   localparam int          CTRL_AUD_EN    = 0;
   localparam int          CTRL_FULL_DUP  = 1;
   localparam int          CTRL_LINK_EN   = 2;
   localparam logic [7:0]  CTRL_RST       = 8'h01;
   localparam logic [7:0]  ERR_THR_RST    = 8'h08;

   // side inputs carried beside the data in each word
   typedef struct packed {
      logic audio;
      logic fwd_ctrl;
   } side_bits_t;

   typedef enum logic [1:0] {
      RC_POWERUP = 2'b00,
      RC_READY   = 2'b01,
      RC_BLOCKED = 2'b11
   } rc_state_t;
endpackage : link_frame_pkg

// file: rtl/link_framer.sv
// link_framer: serializer word builder and deserializer word parser
// assumes i2s and control pins arrive asynchronously, word stream is local
//
// Function
// - bus width select low gives 24-bit bus, high gives 32-bit bus
// - narrow mode ignores the eight upper data inputs
// - audio pins never counted among parallel data bits
// - data bits reproduced in same order at outputs
// - audio disabled: serial data pin carried as an extra data bit
// - each clock: assemble, scramble, line-code, send the word
// - receive: decode, descramble, present word on outputs
// - leading 21 or 29 word bits come from data inputs in order
// - one audio bit encodes the i2s inputs
// - one forward control bit carries control data forward
// - final bit is parity over preceding 23 or 31 bits
// - reverse channel sends control and interrupt back on same pair
// - reverse channel independent of forward control bit
// - reverse channel unused before 500 us after power-up
// - reverse reception blocked 350 us on link start or stop
// - device addresses reset 0x80 and 0x90, writable by host
// - control channel supports 100 kbps to 1 Mbps
// - control link half-duplex or full-duplex selectable
// - narrow mode drives eight upper data outputs low
// - error output low when decode errors exceed threshold
// - lock only when plls locked and word boundary aligned
`timescale 1ns/1ps
module link_framer #(
   parameter int POWERUP_CYCLES = link_frame_pkg::POWERUP_CYC,
   parameter int BLOCK_CYCLES   = link_frame_pkg::BLOCK_CYC
) (
   input  wire logic        clk,          // 40 mhz core clock
   input  wire logic        rst_n,        // async reset, active low
   input  wire logic        bus_width_select, // 0 narrow, 1 wide
   input  wire logic [28:0] din,          // parallel data in
   input  wire logic        i2s_sd,       // i2s serial data pin
   input  wire logic        i2s_sck,      // i2s bit clock pin
   input  wire logic        i2s_ws,       // i2s word select pin
   input  wire logic        fwd_ctrl_in,  // forward control data
   output logic [31:0]      tx_word,      // scrambled word out
   input  wire logic [31:0] rx_word,      // scrambled word in
   input  wire logic        rx_code_err,  // line decoder error
   input  wire logic        pll_locked,   // receive plls locked
   input  wire logic        word_aligned, // word boundary found
   output logic [28:0]      dout,         // parallel data out
   output logic             sd_out,       // received audio bit, raw serial data with audio off
   output logic             audio_carrier_bit, // received audio bit
   output logic             forward_control_bit, // received ctrl bit
   output logic             err_n,        // error, active low
   output logic             lock,         // link locked
   input  wire logic        rev_tx_in,    // reverse ctrl data in
   input  wire logic        rev_line_in,  // reverse line sample
   output logic             rev_line_out, // reverse line drive
   output logic             rev_rx_out,   // reverse data received
   output logic             rev_avail,    // reverse channel usable
   output logic             full_duplex,  // control link mode
   input  wire logic [3:0]  reg_addr,     // register address
   input  wire logic [7:0]  reg_wdata,    // register write data
   input  wire logic        reg_wr,       // write strobe
   input  wire logic        reg_rd,       // read strobe
   output logic [7:0]       reg_rdata     // read data, next cycle
);
   logic [7:0]  serializer_addr_reg;
   logic [7:0]  deserializer_addr_reg;
   logic [7:0]  ctrl;
   logic [7:0]  err_thr;
   logic [7:0]  err_cnt;
   logic [2:0]  sd_s, sck_s, ws_s, fc_s, rvi_s, rvl_s;
   logic        sd_q, sck_q, ws_q, fc_q;
   logic [1:0]  aud_phase;
   logic [15:0] tx_lfsr, rx_lfsr, rx_key;
   logic [31:0] word_plain, rx_plain;
   logic        parity_err, link_en_q;
   link_frame_pkg::side_bits_t side;
   link_frame_pkg::rc_state_t  rc_state;
   logic [31:0] rc_cnt;

   // even parity over the low n bits
   function automatic logic par_over(input logic [31:0] w, input int n);
      logic p;
      p = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (i < n) begin
            p = p ^ w[i];
         end
      end
      return p;
   endfunction : par_over

   // scrambler keystream step, shared by both ends
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_step

   // three-stage synchronisers, change taken when stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sd_s  <= 3'h0;
         sck_s <= 3'h0;
         ws_s  <= 3'h0;
         fc_s  <= 3'h0;
         rvi_s <= 3'h0;
         rvl_s <= 3'h0;
      end else begin
         sd_s  <= {sd_s[1:0], i2s_sd};
         sck_s <= {sck_s[1:0], i2s_sck};
         ws_s  <= {ws_s[1:0], i2s_ws};
         fc_s  <= {fc_s[1:0], fwd_ctrl_in};
         rvi_s <= {rvi_s[1:0], rev_tx_in};
         rvl_s <= {rvl_s[1:0], rev_line_in};
      end
   end

   // filtered levels of the synchronised pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sd_q  <= 1'b0;
         sck_q <= 1'b0;
         ws_q  <= 1'b0;
         fc_q  <= 1'b0;
      end else begin
         if (sd_s[1] == sd_s[2]) sd_q <= sd_s[2];
         if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
         if (ws_s[1] == ws_s[2]) ws_q <= ws_s[2];
         if (fc_s[1] == fc_s[2]) fc_q <= fc_s[2];
      end
   end

   // audio encoding: cycle through sd, sck, ws one per word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aud_phase <= 2'h0;
      end else if (aud_phase == 2'h2) begin
         aud_phase <= 2'h0;
      end else begin
         aud_phase <= aud_phase + 2'h1;
      end
   end

   // side bits of the outgoing word
   always_comb begin
      side.fwd_ctrl = fc_q;
      if (!ctrl[link_frame_pkg::CTRL_AUD_EN]) begin
         side.audio = sd_q;
      end else begin
         case (aud_phase)
            2'h0:    side.audio = sd_q;
            2'h1:    side.audio = sck_q;
            2'h2:    side.audio = ws_q;
            default: side.audio = 1'b0;
         endcase
      end
   end

   // word assembly: data, audio, control, parity
   always_comb begin
      word_plain = 32'h0;
      if (!bus_width_select) begin
         word_plain[20:0] = din[20:0];
         word_plain[21]   = side.audio;
         word_plain[22]   = side.fwd_ctrl;
         word_plain[23]   = par_over(word_plain,
                            link_frame_pkg::NARROW_PAR_POS);
      end else begin
         word_plain[28:0] = din;
         word_plain[29]   = side.audio;
         word_plain[30]   = side.fwd_ctrl;
         word_plain[31]   = par_over(word_plain,
                            link_frame_pkg::WIDE_PAR_POS);
      end
   end

   // transmit scrambler and word register; line coder follows outside
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_lfsr <= link_frame_pkg::SCRAM_SEED;
         tx_word <= 32'h0;
      end else begin
         tx_lfsr <= lfsr_step(tx_lfsr);
         tx_word <= word_plain ^ {2{tx_lfsr}};
      end
   end

   // receive descrambler; key lags one word, matching the transmit register
   assign rx_plain = rx_word ^ {2{rx_key}};
   assign parity_err = bus_width_select ?
      (par_over(rx_plain, link_frame_pkg::WIDE_PAR_POS) != rx_plain[31]) :
      (par_over(rx_plain, link_frame_pkg::NARROW_PAR_POS) != rx_plain[23]);

   // receive outputs; upper lanes low in narrow mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_lfsr             <= link_frame_pkg::SCRAM_SEED;
         rx_key              <= link_frame_pkg::SCRAM_SEED;
         dout                <= 29'h0;
         sd_out              <= 1'b0;
         audio_carrier_bit   <= 1'b0;
         forward_control_bit <= 1'b0;
      end else begin
         rx_lfsr <= lfsr_step(rx_lfsr);
         rx_key  <= rx_lfsr;
         if (!bus_width_select) begin
            dout                <= {8'h0, rx_plain[20:0]};
            audio_carrier_bit   <= rx_plain[21];
            forward_control_bit <= rx_plain[22];
            sd_out              <= rx_plain[21];
         end else begin
            dout                <= rx_plain[28:0];
            audio_carrier_bit   <= rx_plain[29];
            forward_control_bit <= rx_plain[30];
            sd_out              <= rx_plain[29];
         end
      end
   end

   // decode error count, saturating; set wins over software clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_cnt <= 8'h0;
      end else if (lock && (rx_code_err || parity_err)) begin
         if (err_cnt != 8'hff) err_cnt <= err_cnt + 8'h1;
      end else if (reg_wr && reg_addr == link_frame_pkg::REG_ERR_CNT) begin
         err_cnt <= 8'h0;
      end
   end

   // lock and error outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock  <= 1'b0;
         err_n <= 1'b1;
      end else begin
         lock  <= pll_locked && word_aligned;
         err_n <= !(err_cnt > err_thr);
      end
   end

   // reverse channel availability: power-up wait, then block on link change
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rc_state  <= link_frame_pkg::RC_POWERUP;
         rc_cnt    <= 32'h0;
         link_en_q <= 1'b0;
      end else begin
         link_en_q <= ctrl[link_frame_pkg::CTRL_LINK_EN];
         case (rc_state)
            link_frame_pkg::RC_POWERUP: begin
               if (rc_cnt >= 32'(POWERUP_CYCLES - 1)) begin
                  rc_state <= link_frame_pkg::RC_READY;
                  rc_cnt   <= 32'h0;
               end else begin
                  rc_cnt <= rc_cnt + 32'h1;
               end
            end
            link_frame_pkg::RC_READY: begin
               if (link_en_q != ctrl[link_frame_pkg::CTRL_LINK_EN]) begin
                  rc_state <= link_frame_pkg::RC_BLOCKED;
                  rc_cnt   <= 32'h0;
               end
            end
            link_frame_pkg::RC_BLOCKED: begin
               if (link_en_q != ctrl[link_frame_pkg::CTRL_LINK_EN]) begin
                  rc_cnt <= 32'h0;
               end else if (rc_cnt >= 32'(BLOCK_CYCLES - 1)) begin
                  rc_state <= link_frame_pkg::RC_READY;
                  rc_cnt   <= 32'h0;
               end else begin
                  rc_cnt <= rc_cnt + 32'h1;
               end
            end
            default: begin
               rc_state <= link_frame_pkg::RC_POWERUP;
               rc_cnt   <= 32'h0;
            end
         endcase
      end
   end
   assign rev_avail   = (rc_state == link_frame_pkg::RC_READY);
   assign full_duplex = ctrl[link_frame_pkg::CTRL_FULL_DUP];

   // reverse channel path, free of the forward control bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rev_line_out <= 1'b0;
         rev_rx_out   <= 1'b0;
      end else begin
         if (!rev_avail || rvi_s[1] == rvi_s[2]) begin
            rev_line_out <= rev_avail && rvi_s[2];
         end
         if (!rev_avail || rvl_s[1] == rvl_s[2]) begin
            rev_rx_out <= rev_avail && rvl_s[2];
         end
      end
   end

   // register writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serializer_addr_reg   <= link_frame_pkg::SER_ADDR_RST;
         deserializer_addr_reg <= link_frame_pkg::DES_ADDR_RST;
         ctrl                  <= link_frame_pkg::CTRL_RST;
         err_thr               <= link_frame_pkg::ERR_THR_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            link_frame_pkg::REG_SER_ADDR: serializer_addr_reg <= reg_wdata;
            link_frame_pkg::REG_DES_ADDR: deserializer_addr_reg <= reg_wdata;
            link_frame_pkg::REG_CTRL:     ctrl <= reg_wdata;
            link_frame_pkg::REG_ERR_THR:  err_thr <= reg_wdata;
            default: ;
         endcase
      end
   end

   // register reads, data one cycle after the strobe only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            link_frame_pkg::REG_SER_ADDR: reg_rdata <= serializer_addr_reg;
            link_frame_pkg::REG_DES_ADDR: reg_rdata <= deserializer_addr_reg;
            link_frame_pkg::REG_CTRL:     reg_rdata <= ctrl;
            link_frame_pkg::REG_ERR_THR:  reg_rdata <= err_thr;
            link_frame_pkg::REG_STATUS:
               reg_rdata <= {5'h0, rev_avail, !err_n, lock};
            link_frame_pkg::REG_ERR_CNT:  reg_rdata <= err_cnt;
            default:                      reg_rdata <= 8'h0;
         endcase
      end else begin
         reg_rdata <= 8'h0;
      end
   end

   // checks
   chk_narrow_upper: assert property (@(posedge clk)
      disable iff (!rst_n)
      !bus_width_select |=> dout[28:21] == 8'h0 || $past(bus_width_select))
      else $error("upper outputs not low in narrow mode");
   chk_wide_parity: assert property (@(posedge clk)
      disable iff (!rst_n)
      bus_width_select |-> ^word_plain == 1'b0)
      else $error("wide word parity not even");
   chk_narrow_parity: assert property (@(posedge clk)
      disable iff (!rst_n)
      !bus_width_select |-> ^word_plain[23:0] == 1'b0)
      else $error("narrow word parity not even");
   chk_narrow_data: assert property (@(posedge clk)
      disable iff (!rst_n)
      !bus_width_select |-> word_plain[31:24] == 8'h0 &&
      word_plain[20:0] == din[20:0])
      else $error("narrow word layout wrong");
   chk_tx_scramble: assert property (@(posedge clk)
      disable iff (!rst_n)
      1'b1 |=> tx_word == ($past(word_plain) ^ {2{$past(tx_lfsr)}}))
      else $error("transmit word not scrambled plain word");
   chk_lock_cause: assert property (@(posedge clk)
      disable iff (!rst_n)
      !(pll_locked && word_aligned) |=> !lock)
      else $error("lock without plls and alignment");
   chk_err_thresh: assert property (@(posedge clk)
      disable iff (!rst_n)
      err_cnt > err_thr |=> !err_n)
      else $error("error output missed threshold");
   chk_rev_blocked: assert property (@(posedge clk)
      disable iff (!rst_n)
      rev_avail && $changed(ctrl[link_frame_pkg::CTRL_LINK_EN])
      |=> ##1 !rev_avail [*3])
      else $error("reverse channel not blocked on link change");
   chk_powerup_wait: assert property (@(posedge clk)
      disable iff (!rst_n)
      rc_state == link_frame_pkg::RC_POWERUP |-> !rev_avail && !rev_rx_out
      ##1 1'b1)
      else $error("reverse channel used during power-up");
   chk_addr_write: assert property (@(posedge clk)
      disable iff (!rst_n)
      reg_wr && reg_addr == link_frame_pkg::REG_SER_ADDR
      |=> serializer_addr_reg == $past(reg_wdata))
      else $error("address register write lost");
   cov_wide_word: cover property (@(posedge clk) disable iff (!rst_n)
      bus_width_select ##1 bus_width_select);
   cov_err_low: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(err_n));
   cov_rev_ready: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(rev_avail));
   cov_audio_off: cover property (@(posedge clk) disable iff (!rst_n)
      !ctrl[link_frame_pkg::CTRL_AUD_EN]);
endmodule : link_framer

// file: verification/link_partner.sv
// partner: far end of the serial pair, loops the word stream back
// assumes the receive side of the framer shares the core clock
`timescale 1ns/1ps
module link_partner (
   input  wire logic [31:0] tx_word,      // word from serializer
   input  wire logic        flip,         // corrupt bit 0 of the word
   input  wire logic        code_err,     // inject a decoder error
   input  wire logic        pll_ok,       // receive plls locked
   input  wire logic        align_ok,     // word boundary found
   input  wire logic        rev_bit,      // reverse data to send
   output logic [31:0]      rx_word,      // word to deserializer
   output logic             rx_code_err,  // line decoder error
   output logic             pll_locked,   // lock status
   output logic             word_aligned, // alignment status
   output logic             rev_line_in   // reverse line level
);
   // word crosses the pair unchanged unless a fault is commanded
   assign rx_word      = tx_word ^ {31'h0, flip};
   // status seen by the receive plls and line decoder
   assign rx_code_err  = code_err;
   assign pll_locked   = pll_ok;
   assign word_aligned = align_ok;
   // reverse traffic runs regardless of forward words
   assign rev_line_in  = rev_bit;
endmodule : link_partner

// file: verification/serial_link_frame_format_tb_top.sv
// testbench: link_framer against a loopback partner, self-checking
// assumes reverse counts shortened to 20 and 10 cycles
`timescale 1ns/1ps
module serial_link_frame_format_tb_top;
   localparam int PWR = 20;
   localparam int BLK = 10;
   logic        clk, rst_n, bus_width_select, i2s_sd, i2s_sck, i2s_ws;
   logic        fwd_ctrl_in, flip, code_err, pll_ok, align_ok, rev_bit;
   logic        rev_tx_in, reg_wr, reg_rd, err_n, lock, sd_out;
   logic        audio_carrier_bit, forward_control_bit, rev_line_out;
   logic        rev_rx_out, rev_avail, full_duplex, rx_code_err;
   logic        pll_locked, word_aligned, rev_line_in;
   logic [28:0] din, dout;
   logic [31:0] tx_word, rx_word, seed, ones;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   logic [28:0] exp_q[$];
   int          err_total, checked, cycles;

   link_framer #(.POWERUP_CYCLES(PWR), .BLOCK_CYCLES(BLK)) u_dut (
      .clk, .rst_n, .bus_width_select, .din, .i2s_sd, .i2s_sck, .i2s_ws,
      .fwd_ctrl_in, .tx_word, .rx_word, .rx_code_err, .pll_locked,
      .word_aligned, .dout, .sd_out, .audio_carrier_bit,
      .forward_control_bit, .err_n, .lock, .rev_tx_in, .rev_line_in,
      .rev_line_out, .rev_rx_out, .rev_avail, .full_duplex, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

   link_partner u_far (
      .tx_word, .flip, .code_err, .pll_ok, .align_ok, .rev_bit, .rx_word,
      .rx_code_err, .pll_locked, .word_aligned, .rev_line_in);

   // 40 mhz core clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // pseudo-random source for data and register values
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen,
                  exp);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      check(32'(reg_rdata), 32'(e));
   endtask : rd

   // random words through the loop, expected word kept in a queue
   task automatic words(input logic w);
      @(posedge clk);
      bus_width_select <= w;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         seed = lfsr(seed);
         din <= seed[28:0];
         exp_q.push_back(w ? seed[28:0] : {8'h00, seed[20:0]});
         step(3);
         check(32'(dout), 32'(exp_q.pop_front()));
      end
   endtask : words

   task automatic summarize();
      $display("mismatches %0d, comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         summarize();
      end
   end

   // main sequence
   initial begin
      {err_total, checked, cycles} = '0;
      {rst_n, bus_width_select, i2s_sd, i2s_sck, i2s_ws} = '0;
      {fwd_ctrl_in, flip, code_err, reg_wr, reg_rd} = '0;
      {pll_ok, align_ok, rev_bit, rev_tx_in} = 4'hf;
      din = '0;
      reg_addr = '0;
      reg_wdata = '0;
      seed = 32'h9bb0bec2;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      step(10);
      check(32'(rev_avail), 32'h0);
      check(32'(rev_line_out), 32'h0);
      check(32'(rev_rx_out), 32'h0);
      step(20);
      check(32'(rev_avail), 32'h1);
      check(32'(rev_line_out), 32'h1);
      check(32'(rev_rx_out), 32'h1);
      // reverse path moves against the forward bit, then alongside it
      @(posedge clk);
      rev_tx_in <= 1'b0;
      fwd_ctrl_in <= 1'b1;
      step(10);
      check(32'(rev_line_out), 32'h0);
      check(32'(forward_control_bit), 32'h1);
      @(posedge clk);
      fwd_ctrl_in <= 1'b0;
      rev_bit <= 1'b0;
      step(10);
      check(32'(rev_rx_out), 32'h0);
      check(32'(forward_control_bit), 32'h0);
      // address registers, unmapped place
      rd(link_frame_pkg::REG_SER_ADDR, 8'h80);
      rd(link_frame_pkg::REG_DES_ADDR, 8'h90);
      rd(4'hf, 8'h00);
      seed = lfsr(seed);
      wr(link_frame_pkg::REG_SER_ADDR, seed[7:0]);
      wr(link_frame_pkg::REG_DES_ADDR, seed[15:8]);
      rd(link_frame_pkg::REG_SER_ADDR, seed[7:0]);
      rd(link_frame_pkg::REG_DES_ADDR, seed[15:8]);
      words(1'b0);
      words(1'b1);
      // audio enabled: three words together carry all three pins
      for (int p = 0; p < 8; p++) begin
         @(posedge clk);
         {i2s_sd, i2s_sck, i2s_ws} <= p[2:0];
         step(10);
         ones = '0;
         repeat (3) begin
            ones = ones + 32'(audio_carrier_bit);
            step(1);
         end
         check(ones, 32'($countones(p[2:0])));
      end
      // audio off, full duplex on: raw serial data rides the word
      wr(link_frame_pkg::REG_CTRL, 8'h02);
      rd(link_frame_pkg::REG_CTRL, 8'h02);
      check(32'(full_duplex), 32'h1);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         {i2s_sd, i2s_sck, i2s_ws} <= {p[0], ~p[0], ~p[0]};
         step(10);
         check(32'(sd_out), 32'(p[0]));
         check(32'(audio_carrier_bit), 32'(p[0]));
      end
      // error threshold of 3: code and parity errors both count
      wr(link_frame_pkg::REG_ERR_THR, 8'h03);
      wr(link_frame_pkg::REG_ERR_CNT, 8'h00);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         flip <= k[0];
         code_err <= ~k[0];
         @(posedge clk);
         {flip, code_err} <= 2'b00;
         step(3);
         check(32'(err_n), 32'(k < 3));
      end
      rd(link_frame_pkg::REG_ERR_CNT, 8'h04);
      wr(link_frame_pkg::REG_ERR_CNT, 8'h00);
      step(3);
      check(32'(err_n), 32'h1);
      // lock needs both plls and alignment; errors unlocked ignored
      @(posedge clk);
      pll_ok <= 1'b0;
      step(3);
      check(32'(lock), 32'h0);
      @(posedge clk);
      code_err <= 1'b1;
      @(posedge clk);
      code_err <= 1'b0;
      pll_ok <= 1'b1;
      align_ok <= 1'b0;
      step(3);
      check(32'(lock), 32'h0);
      @(posedge clk);
      align_ok <= 1'b1;
      step(3);
      check(32'(lock), 32'h1);
      rd(link_frame_pkg::REG_ERR_CNT, 8'h00);
      // link start then stop each block the reverse channel
      for (int s = 0; s < 2; s++) begin
         wr(link_frame_pkg::REG_CTRL, s ? 8'h02 : 8'h06);
         step(2);
         check(32'(rev_avail), 32'h0);
         step(BLK - 3);
         check(32'(rev_avail), 32'h0);
         step(6);
         check(32'(rev_avail), 32'h1);
      end
      summarize();
   end
endmodule : serial_link_frame_format_tb_top
